// [rtl/memory_reference_instr_exec.sv]
// decode and execute of the upper memory-reference instruction group
module memory_reference_instr_exec
  import mem_ref_exec_pkg::*;
#(
  parameter int IRQ_LINES = 4
) (
  input wire logic clk_sys, // core clock
  input wire logic srst, // synchronous reset
  input wire logic instrValid, // instruction offered
  input wire logic [16:0] instrWord, // instruction word
  input wire logic [15:0] operandAddr, // effective address from address unit
  input wire logic [15:0] stackPointer, // stack pointer register value
  input wire logic [16:0] memRdData, // data memory read word
  input wire logic repeatStep, // one repeated instruction done
  input wire logic tableLoad, // table lookup writes pointer
  input wire logic [15:0] tableValue, // value from table lookup
  input wire logic [IRQ_LINES-1:0] irqRequest, // interrupt request pulses
  input wire logic [3:0] regAddr, // register port index
  input wire logic [16:0] regWrData, // register write data
  input wire logic regWr, // register write strobe
  input wire logic regRd, // register read strobe
  output logic [16:0] regRdData, // register read data
  output logic [15:0] memAddr, // data memory address
  output logic memRdEn, // data memory read strobe
  output logic memWrEn, // data memory write strobe
  output logic [16:0] memWrData, // data memory write word
  output logic busy, // sequencer not idle
  output logic pcLoad, // program counter load pulse
  output logic [15:0] pcValue, // new program counter
  output logic intReturn, // interrupt routine finished pulse
  output logic irqServe, // interrupt dispatch pulse
  output logic [$clog2(IRQ_LINES)-1:0] irqIndex, // dispatched line
  output logic [16:0] statusReg, // status register
  output logic [15:0] stackTop, // stack top register
  output logic [15:0] productHigh, // product high register
  output logic [15:0] multiplier // multiplier register
);
  localparam int IDX_W = $clog2(IRQ_LINES);

  typedef struct packed {
    state_type fsm;
    logic [4:0] op;
    logic [15:0] memAddr;
    logic memRdEn;
    logic memWrEn;
    logic [16:0] memWrData;
    logic [15:0] stackTop;
    logic [SHIFT_W-1:0] shiftValue;
    logic [15:0] productHigh;
    logic [STR_W-1:0] stringLen;
    logic [3:0][AP_W-1:0] accPtr;
    logic [15:0] multiplier;
    logic [RPT_W-1:0] rptCount;
    logic [16:0] status;
    logic [15:0] tablePtr;
    logic pcLoad;
    logic [15:0] pcValue;
    logic intReturn;
    logic [IRQ_LINES-1:0] irqPending;
    logic irqServe;
    logic [IDX_W-1:0] irqIndex;
    logic [16:0] regRdData;
    logic busy;
  } state_reg_type;

  state_reg_type q, d;

  // zero and sign flags of a transferred word
  function automatic logic [16:0] xferStatus(input logic [16:0] st, input logic [15:0] v);
    logic [16:0] r;
    r = st;
    r[ST_ZERO] = (v == 16'h0000);
    r[ST_SIGN] = v[15];
    return r;
  endfunction : xferStatus

  // upper product half, signed or unsigned, optionally rounded
  function automatic logic [15:0] mulHigh(input logic [15:0] a, input logic [15:0] b,
                                          input logic uns, input logic rnd);
    logic [31:0] p;
    p = uns ? ({16'h0000, a} * {16'h0000, b}) : 32'($signed(a) * $signed(b));
    if (rnd) begin
      p = p + ROUND_CONST;
    end
    return p[31:16];
  endfunction : mulHigh

  // lowest pending interrupt line
  function automatic logic [IDX_W-1:0] firstSet(input logic [IRQ_LINES-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = IRQ_LINES - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction : firstSet

  // true when the word belongs to the class with an operation code of OP_FIRST or above; returns only as RET_WORD or INTERRUPT_RETURN_WORD
  function automatic logic isMine(input logic [16:0] w);
    logic [4:0] f;
    f = w[OP_HI:OP_LO];
    if (w[PREFIX_HI:PREFIX_LO] != CLASS_PREFIX || f < OP_FIRST) begin
      return 1'b0;
    end
    if (f == OP_RET) begin
      return w == RET_WORD;
    end
    if (f == OP_INTERRUPT_RETURN) begin
      return w == INTERRUPT_RETURN_WORD;
    end
    return 1'b1;
  endfunction : isMine

  // next state of the whole block
  always_comb begin
    logic [15:0] lo;
    logic tagIn;
    lo = memRdData[15:0];
    tagIn = 1'b0;
    d = q;
    d.memRdEn = 1'b0;
    d.memWrEn = 1'b0;
    d.pcLoad = 1'b0;
    d.intReturn = 1'b0;
    d.irqServe = 1'b0;
    // register port; status is the only word software may write
    if (regWr && regAddr == REG_STATUS) begin
      d.status = regWrData;
    end
    // table pointer follows lookups only
    if (tableLoad) begin
      d.tablePtr = tableValue;
    end
    // repeat counter runs down as repeated instructions finish
    if (repeatStep && q.rptCount != '0) begin
      d.rptCount = q.rptCount - RPT_W'(1);
    end
    // queue requests; held while repetition is active
    if (q.rptCount == '0 && q.irqPending != '0) begin
      d.irqServe = 1'b1;
      d.irqIndex = firstSet(q.irqPending);
      d.irqPending[firstSet(q.irqPending)] = 1'b0;
    end
    d.irqPending = d.irqPending | irqRequest;
    case (q.fsm)
      IDLE: begin
        if (instrValid && isMine(instrWord)) begin
          d.op = instrWord[OP_HI:OP_LO];
          d.memAddr = operandAddr;
          if (instrWord[OP_HI:OP_LO] == OP_STORE_TOS) begin
            d.memWrEn = 1'b1;
            d.memWrData = {1'b0, q.stackTop};
            d.status = xferStatus(d.status, q.stackTop);
          end else begin
            if (instrWord == RET_WORD || instrWord == INTERRUPT_RETURN_WORD) begin
              d.memAddr = stackPointer;
            end
            d.memRdEn = 1'b1;
            d.fsm = WAIT;
          end
        end
      end
      WAIT: begin
        d.fsm = EXEC;
      end
      EXEC: begin
        d.fsm = IDLE;
        if (q.op[4:2] == OP_LD_AP_HI) begin
          d.accPtr[q.op[1:0]] = memRdData[AP_W-1:0];
          d.status = xferStatus(d.status, lo);
        end else begin
          case (q.op)
            OP_SET_TAG, OP_CLR_TAG, OP_FLAG_TAG0, OP_FLAG_TAG1: begin
              case (q.op)
                OP_SET_TAG: tagIn = 1'b1;
                OP_CLR_TAG: tagIn = 1'b0;
                OP_FLAG_TAG0: tagIn = q.status[ST_TF1];
                default: tagIn = q.status[ST_TF2];
              endcase
              d.memWrEn = 1'b1;
              d.memWrData = {tagIn, lo};
            end
            OP_LD_SHIFT: begin
              d.shiftValue = memRdData[SHIFT_W-1:0];
              d.status = xferStatus(d.status, lo);
            end
            OP_LD_PH: begin
              d.productHigh = lo;
              d.status = xferStatus(d.status, lo);
            end
            OP_LD_TOS: begin
              d.stackTop = lo;
            end
            OP_LD_STR: begin
              d.stringLen = memRdData[STR_W-1:0];
              d.status = xferStatus(d.status, {8'h00, memRdData[STR_W-1:0]});
            end
            OP_LD_MR, OP_LD_MRU: begin
              d.multiplier = lo;
              d.status = xferStatus(d.status, lo);
              d.status[ST_UM] = (q.op == OP_LD_MRU);
            end
            OP_MUL_RND: begin
              d.productHigh = mulHigh(q.multiplier, lo, q.status[ST_UM], 1'b1);
            end
            OP_MUL: begin
              d.productHigh = mulHigh(q.multiplier, lo, q.status[ST_UM], 1'b0);
            end
            OP_RET, OP_INTERRUPT_RETURN: begin
              d.pcLoad = 1'b1;
              d.pcValue = lo;
              d.intReturn = (q.op == OP_INTERRUPT_RETURN);
            end
            OP_LD_RPT: begin
              d.rptCount = memRdData[RPT_W-1:0];
            end
            OP_LD_STAT: begin
              d.status = memRdData;
            end
            default: begin
              d.fsm = IDLE;
            end
          endcase
        end
      end
      default: begin
        d.fsm = IDLE;
      end
    endcase
    d.busy = (d.fsm != IDLE);
    // read data stands for the one cycle after the strobe
    d.regRdData = 17'h00000;
    if (regRd) begin
      case (regAddr)
        REG_STATUS: d.regRdData = q.status;
        REG_STACK_TOP: d.regRdData = {1'b0, q.stackTop};
        REG_SHIFT: d.regRdData = {13'h0000, q.shiftValue};
        REG_PH: d.regRdData = {1'b0, q.productHigh};
        REG_STR: d.regRdData = {9'h000, q.stringLen};
        REG_MR: d.regRdData = {1'b0, q.multiplier};
        REG_RPT: d.regRdData = {9'h000, q.rptCount};
        REG_TABLE_PTR: d.regRdData = {1'b0, q.tablePtr};
        REG_PC: d.regRdData = {1'b0, q.pcValue};
        REG_IRQ_PEND: d.regRdData = 17'(q.irqPending);
        REG_AP0, REG_AP0 + 4'h1, REG_AP0 + 4'h2, REG_AP0 + 4'h3:
          d.regRdData = {12'h000, q.accPtr[regAddr[1:0]]};
        default: d.regRdData = 17'h00000;
      endcase
    end
    if (srst) begin
      d = '0;
      d.fsm = IDLE;
      d.status = STATUS_RST;
      d.stackTop = WORD_RST;
    end
  end

  // the whole state is one register
  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  // outputs straight from the state register
  assign regRdData = q.regRdData;
  assign memAddr = q.memAddr;
  assign memRdEn = q.memRdEn;
  assign memWrEn = q.memWrEn;
  assign memWrData = q.memWrData;
  assign busy = q.busy;
  assign pcLoad = q.pcLoad;
  assign pcValue = q.pcValue;
  assign intReturn = q.intReturn;
  assign irqServe = q.irqServe;
  assign irqIndex = q.irqIndex;
  assign statusReg = q.status;
  assign stackTop = q.stackTop;
  assign productHigh = q.productHigh;
  assign multiplier = q.multiplier;

  // checks on instruction execution, interrupt hold and table pointer
  sequence execOf(logic [4:0] code);
    q.fsm == EXEC && q.op == code;
  endsequence

  sequence tagExec;
    q.fsm == EXEC && q.op >= OP_SET_TAG && q.op <= OP_FLAG_TAG1;
  endsequence

  a_store_top_write: assert property (@(posedge clk_sys) disable iff (srst)
    (q.fsm == IDLE && instrValid && instrWord[16:8] == {CLASS_PREFIX, OP_STORE_TOS})
    |=> memWrEn && memWrData == {1'b0, $past(q.stackTop)}
        && statusReg[ST_ZERO] == ($past(q.stackTop) == 16'h0000))
    else $error("stack top store wrong");

  a_tag_set_word: assert property (@(posedge clk_sys) disable iff (srst)
    execOf(OP_SET_TAG) |=> memWrEn && memWrData == {1'b1, $past(memRdData[15:0])})
    else $error("set tag word wrong");

  a_tag_clear_word: assert property (@(posedge clk_sys) disable iff (srst)
    execOf(OP_CLR_TAG) |=> memWrEn && memWrData == {1'b0, $past(memRdData[15:0])})
    else $error("clear tag word wrong");

  a_tag_status_kept: assert property (@(posedge clk_sys) disable iff (srst)
    (tagExec and !regWr) |=> $stable(statusReg))
    else $error("tag op changed status");

  a_flag_tag_copy: assert property (@(posedge clk_sys) disable iff (srst)
    execOf(OP_FLAG_TAG0) |=> memWrData[TAG_BIT] == $past(q.status[ST_TF1]))
    else $error("flag to tag wrong");

  a_string_low_bits: assert property (@(posedge clk_sys) disable iff (srst)
    execOf(OP_LD_STR) |=> q.stringLen == $past(memRdData[7:0]))
    else $error("string load wrong");

  a_unsigned_mode: assert property (@(posedge clk_sys) disable iff (srst)
    execOf(OP_LD_MRU) |=> statusReg[ST_UM] && multiplier == $past(memRdData[15:0]))
    else $error("unsigned load wrong");

  a_round_product: assert property (@(posedge clk_sys) disable iff (srst)
    execOf(OP_MUL_RND) |=> productHigh ==
      mulHigh($past(q.multiplier), $past(memRdData[15:0]), $past(q.status[ST_UM]), 1'b1))
    else $error("rounded product wrong");

  a_return_pc: assert property (@(posedge clk_sys) disable iff (srst)
    (q.fsm == IDLE && instrValid && instrWord == RET_WORD)
    |=> memRdEn && memAddr == $past(stackPointer) ##2 pcLoad && !intReturn)
    else $error("return sequence wrong");

  a_irq_held: assert property (@(posedge clk_sys) disable iff (srst)
    q.rptCount != '0 |=> !irqServe)
    else $error("interrupt served during repeat");

  // loads, tag ops and returns keep the sequencer busy for two cycles
  a_busy_window: assert property (@(posedge clk_sys) disable iff (srst)
    (q.fsm == IDLE && instrValid && isMine(instrWord)
      && instrWord[OP_HI:OP_LO] != OP_STORE_TOS) |=> busy ##1 busy ##1 !busy)
    else $error("load sequence length wrong");

  a_flag_two_copy: assert property (@(posedge clk_sys) disable iff (srst)
    execOf(OP_FLAG_TAG1) |=> memWrData[TAG_BIT] == $past(q.status[ST_TF2]))
    else $error("second flag to tag wrong");

  a_pointer_low_bits: assert property (@(posedge clk_sys) disable iff (srst)
    (q.fsm == EXEC && q.op[4:2] == OP_LD_AP_HI)
    |=> q.accPtr[$past(q.op[1:0])] == $past(memRdData[AP_W-1:0])
        && statusReg[ST_ZERO] == ($past(memRdData[15:0]) == 16'h0000))
    else $error("pointer load wrong");

  a_int_return_pc: assert property (@(posedge clk_sys) disable iff (srst)
    (q.fsm == IDLE && instrValid && instrWord == INTERRUPT_RETURN_WORD)
    |=> memRdEn && memAddr == $past(stackPointer)
        ##2 pcLoad && intReturn && pcValue == $past(memRdData[15:0]))
    else $error("interrupt return sequence wrong");

  a_status_full_load: assert property (@(posedge clk_sys) disable iff (srst)
    execOf(OP_LD_STAT) |=> statusReg == $past(memRdData))
    else $error("status load wrong");

  a_table_ptr_kept: assert property (@(posedge clk_sys) disable iff (srst)
    !tableLoad |=> $stable(q.tablePtr))
    else $error("table pointer changed without lookup");
endmodule : memory_reference_instr_exec

// [inc/mem_ref_exec_pkg.sv]
// constants, encodings and types for the memory-reference execute block
package mem_ref_exec_pkg;
  // instruction word layout
  localparam int WORD_W = 17;
  localparam int DATA_W = 16;
  localparam int TAG_BIT = 16;
  localparam logic [3:0] CLASS_PREFIX = 4'hD;
  localparam int PREFIX_HI = 16;
  localparam int PREFIX_LO = 13;
  localparam int OP_HI = 12;
  localparam int OP_LO = 8;
  // operation field codes handled here
  localparam logic [4:0] OP_STORE_TOS = 5'h0B;
  localparam logic [4:0] OP_SET_TAG = 5'h0C;
  localparam logic [4:0] OP_CLR_TAG = 5'h0D;
  localparam logic [4:0] OP_FLAG_TAG0 = 5'h0E;
  localparam logic [4:0] OP_FLAG_TAG1 = 5'h0F;
  localparam logic [4:0] OP_LD_SHIFT = 5'h10;
  localparam logic [4:0] OP_LD_PH = 5'h11;
  localparam logic [4:0] OP_LD_TOS = 5'h12;
  localparam logic [4:0] OP_LD_STR = 5'h13;
  localparam logic [2:0] OP_LD_AP_HI = 3'h5;
  localparam logic [4:0] OP_LD_MR = 5'h18;
  localparam logic [4:0] OP_LD_MRU = 5'h19;
  localparam logic [4:0] OP_MUL_RND = 5'h1A;
  localparam logic [4:0] OP_MUL = 5'h1B;
  localparam logic [4:0] OP_RET = 5'h1C;
  localparam logic [4:0] OP_INTERRUPT_RETURN = 5'h1D;
  localparam logic [4:0] OP_LD_RPT = 5'h1E;
  localparam logic [4:0] OP_LD_STAT = 5'h1F;
  localparam logic [4:0] OP_FIRST = 5'h0B;
  // complete return words
  localparam logic [16:0] RET_WORD = 17'h1BC7E;
  localparam logic [16:0] INTERRUPT_RETURN_WORD = 17'h1BD7E;
  // status register bit positions
  localparam int ST_ZERO = 0;
  localparam int ST_SIGN = 1;
  localparam int ST_UM = 2;
  localparam int ST_TF1 = 3;
  localparam int ST_TF2 = 4;
  // widths of the loaded registers
  localparam int SHIFT_W = 4;
  localparam int STR_W = 8;
  localparam int AP_W = 5;
  localparam int RPT_W = 8;
  localparam logic [31:0] ROUND_CONST = 32'h00008000;
  // register port indices
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_STACK_TOP = 4'h1;
  localparam logic [3:0] REG_SHIFT = 4'h2;
  localparam logic [3:0] REG_PH = 4'h3;
  localparam logic [3:0] REG_STR = 4'h4;
  localparam logic [3:0] REG_MR = 4'h5;
  localparam logic [3:0] REG_RPT = 4'h6;
  localparam logic [3:0] REG_TABLE_PTR = 4'h7;
  localparam logic [3:0] REG_PC = 4'h8;
  localparam logic [3:0] REG_IRQ_PEND = 4'h9;
  localparam logic [3:0] REG_AP0 = 4'hC;
  // reset values
  localparam logic [16:0] STATUS_RST = 17'h00000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // execution sequencer
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    WAIT = 2'b01,
    EXEC = 2'b10
  } state_type;
endpackage : mem_ref_exec_pkg

// [verification/data_mem_model.sv]
// behavioural 17 bit data memory at the far side of the execute block
module data_mem_model (
  input wire logic clk_sys, // core clock
  input wire logic [15:0] memAddr, // word address
  input wire logic memRdEn, // read strobe
  input wire logic memWrEn, // write strobe
  input wire logic [16:0] memWrData, // write word
  output logic [16:0] memRdData // read word, one cycle after strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] store [256];
  logic [16:0] lastQ;
  logic validQ;
  // write on strobe, fetch on read strobe
  always @(posedge clk_sys) begin
    if (memWrEn === 1'b1) begin
      store[memAddr[7:0]] <= memWrData;
    end
    validQ <= memRdEn;
    if (memRdEn === 1'b1) begin
      lastQ <= store[memAddr[7:0]];
    end
  end
  // outside the answer cycle the bus shows the inverse of the last word
  assign memRdData = validQ ? lastQ : ~lastQ;
endmodule : data_mem_model

// [verification/memory_reference_instr_exec_bench.sv]
// self-checking bench for the memory-reference execute block
module memory_reference_instr_exec_bench;
  import mem_ref_exec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, srst, instrValid, repeatStep, tableLoad, regWr, regRd;
  logic [16:0] instrWord, memRdData, regWrData, regRdData, memWrData, statusReg;
  logic [15:0] operandAddr, stackPointer, tableValue, memAddr, pcValue;
  logic [15:0] stackTop, productHigh, multiplier;
  logic [3:0] irqRequest, regAddr;
  logic memRdEn, memWrEn, busy, pcLoad, intReturn, irqServe, sawPc, sawInt, sawBusy;
  logic [1:0] irqIndex, lastIndex;
  int numErrors = 0;
  int testsRun = 0;
  int servedCount = 0;
  int cycles = 0;

  memory_reference_instr_exec DUT (
    .clk_sys(clk_sys), .srst(srst), .instrValid(instrValid), .instrWord(instrWord),
    .operandAddr(operandAddr), .stackPointer(stackPointer), .memRdData(memRdData),
    .repeatStep(repeatStep), .tableLoad(tableLoad), .tableValue(tableValue),
    .irqRequest(irqRequest), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .memAddr(memAddr), .memRdEn(memRdEn),
    .memWrEn(memWrEn), .memWrData(memWrData), .busy(busy), .pcLoad(pcLoad),
    .pcValue(pcValue), .intReturn(intReturn), .irqServe(irqServe), .irqIndex(irqIndex),
    .statusReg(statusReg), .stackTop(stackTop), .productHigh(productHigh),
    .multiplier(multiplier));

  data_mem_model mem (.clk_sys(clk_sys), .memAddr(memAddr), .memRdEn(memRdEn),
    .memWrEn(memWrEn), .memWrData(memWrData), .memRdData(memRdData));

  always #5 clk_sys = ~clk_sys;

  // interrupt dispatch monitor and run limit
  always @(posedge clk_sys) begin
    if (irqServe === 1'b1) begin
      servedCount++;
      lastIndex = irqIndex;
    end
    cycles++;
    if (cycles == 5000) begin
      numErrors++;
      completeRun();
    end
  end

  task automatic completeRun();
    $display("checks %0d errors %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : completeRun

  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    testsRun++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      numErrors++;
    end
  endtask : chk

  function automatic logic [16:0] op(input logic [4:0] code);
    return {CLASS_PREFIX, code, 8'h00};
  endfunction : op

  task automatic regWrite(input logic [3:0] a, input logic [16:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : regWrite

  task automatic regRead(input string what, input logic [3:0] a, input logic [16:0] exp);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    chk(what, exp, regRdData);
  endtask : regRead

  // offer one instruction, catch the c3 pulses, then let writes land
  task automatic exec(input logic [16:0] word, input logic [15:0] addr);
    @(posedge clk_sys);
    instrValid <= 1'b1;
    instrWord <= word;
    operandAddr <= addr;
    @(posedge clk_sys);
    instrValid <= 1'b0;
    #1;
    sawBusy = busy;
    repeat (2) @(posedge clk_sys);
    #1;
    sawPc = pcLoad;
    sawInt = intReturn;
    @(posedge clk_sys);
    #1;
  endtask : exec

  initial begin
    clk_sys = 0; srst = 1; instrValid = 0; instrWord = 0; operandAddr = 0;
    stackPointer = 0; repeatStep = 0; tableLoad = 0; tableValue = 0; irqRequest = 0;
    regAddr = 0; regWrData = 0; regWr = 0; regRd = 0;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk("status after reset", 17'h00000, statusReg);
    // register port: status write, unmapped read, table pointer read only
    regWrite(REG_STATUS, 17'h00008);
    regRead("status", REG_STATUS, 17'h00008);
    regRead("unmapped", 4'hA, 17'h00000);
    @(posedge clk_sys);
    tableLoad <= 1'b1;
    tableValue <= 16'h1234;
    @(posedge clk_sys);
    tableLoad <= 1'b0;
    regWrite(REG_TABLE_PTR, 17'h0FFFF);
    regRead("table pointer", REG_TABLE_PTR, 17'h01234);
    // tag operations with test flag one set, two clear
    mem.store[8'h10] = 17'h0ABCD;
    exec(op(OP_SET_TAG), 16'h0010);
    chk("set tag word", 17'h1ABCD, mem.store[8'h10]);
    exec(op(OP_CLR_TAG), 16'h0010);
    chk("clear tag word", 17'h0ABCD, mem.store[8'h10]);
    exec(op(OP_FLAG_TAG0), 16'h0010);
    chk("flag one to tag", 17'h1ABCD, mem.store[8'h10]);
    exec(op(OP_FLAG_TAG1), 16'h0010);
    chk("flag two to tag", 17'h0ABCD, mem.store[8'h10]);
    chk("status after tag ops", 17'h00008, statusReg);
    // stack top load and store
    mem.store[8'h20] = 17'h18000;
    exec(op(OP_LD_TOS), 16'h0020);
    chk("stack top", 17'h08000, {1'b0, stackTop});
    chk("status after stack load", 17'h00008, statusReg);
    exec(op(OP_STORE_TOS), 16'h0021);
    chk("busy on store", 17'h00000, {16'h0000, sawBusy});
    chk("stored stack top", 17'h08000, mem.store[8'h21]);
    chk("status after store", 17'h0000A, statusReg);
    // narrow register and product high loads and their transfer status
    mem.store[8'h30] = 17'h1FFF5;
    exec(op(OP_LD_SHIFT), 16'h0030);
    regRead("shift value", REG_SHIFT, 17'h00005);
    chk("status after shift load", 17'h0000A, statusReg);
    mem.store[8'h31] = 17'h00000;
    exec(op(OP_LD_PH), 16'h0031);
    chk("product high load", 17'h00000, {1'b0, productHigh});
    chk("status after ph load", 17'h00009, statusReg);
    mem.store[8'h32] = 17'h0FF00;
    exec(op(OP_LD_STR), 16'h0032);
    regRead("string length", REG_STR, 17'h00000);
    chk("status after string load", 17'h00009, statusReg);
    mem.store[8'h33] = 17'h00020;
    exec(op({OP_LD_AP_HI, 2'b10}), 16'h0033);
    regRead("pointer two", REG_AP0 + 4'h2, 17'h00000);
    chk("status after pointer load", 17'h00008, statusReg);
    // multiplier loads and multiplies, signed then unsigned
    mem.store[8'h40] = 17'h0FFFE;
    mem.store[8'h41] = 17'h00003;
    mem.store[8'h42] = 17'h04000;
    exec(op(OP_LD_MR), 16'h0040);
    chk("busy during load", 17'h00001, {16'h0000, sawBusy});
    chk("idle after load", 17'h00000, {16'h0000, busy});
    chk("multiplier", 17'h0FFFE, {1'b0, multiplier});
    chk("status signed load", 17'h0000A, statusReg);
    exec(op(OP_MUL), 16'h0041);
    chk("signed product", 17'h0FFFF, {1'b0, productHigh});
    exec(op(OP_MUL_RND), 16'h0042);
    chk("signed rounded", 17'h00000, {1'b0, productHigh});
    chk("status after multiply", 17'h0000A, statusReg);
    exec(op(OP_LD_MRU), 16'h0040);
    chk("status unsigned load", 17'h0000E, statusReg);
    chk("unsigned multiplier", 17'h0FFFE, {1'b0, multiplier});
    exec(op(OP_MUL), 16'h0041);
    chk("unsigned product", 17'h00002, {1'b0, productHigh});
    exec(op(OP_MUL_RND), 16'h0042);
    chk("unsigned rounded", 17'h04000, {1'b0, productHigh});
    // returns through the stack pointer, near miss ignored
    @(posedge clk_sys);
    stackPointer <= 16'h0050;
    mem.store[8'h50] = 17'h00456;
    exec(RET_WORD, 16'h0000);
    chk("return pc", 17'h00456, {sawPc ? 1'b0 : 1'b1, pcValue});
    chk("return not interrupt", 17'h00000, {16'h0000, sawInt});
    mem.store[8'h50] = 17'h00789;
    exec(INTERRUPT_RETURN_WORD, 16'h0000);
    chk("interrupt return pc", 17'h00789, {sawPc ? 1'b0 : 1'b1, pcValue});
    chk("interrupt return end", 17'h00001, {16'h0000, sawInt});
    exec(RET_WORD ^ 17'h00001, 16'h0000);
    chk("partial return word", 17'h00789, {sawPc, pcValue});
    // repeat load holds interrupts back until the count runs out
    mem.store[8'h60] = 17'h1FF02;
    exec(op(OP_LD_RPT), 16'h0060);
    regRead("repeat counter", REG_RPT, 17'h00002);
    @(posedge clk_sys);
    irqRequest <= 4'h2;
    @(posedge clk_sys);
    irqRequest <= 4'h0;
    repeat (4) @(posedge clk_sys);
    chk("served while repeating", 17'h00000, 17'(servedCount));
    repeat (2) begin
      @(posedge clk_sys);
      repeatStep <= 1'b1;
      @(posedge clk_sys);
      repeatStep <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    #1;
    chk("served after repeat", 17'h00001, 17'(servedCount));
    chk("served line", 17'h00001, {15'h0000, lastIndex});
    // full status load including tag
    mem.store[8'h70] = 17'h10015;
    exec(op(OP_LD_STAT), 16'h0070);
    chk("status load", 17'h10015, statusReg);
    completeRun();
  end
endmodule : memory_reference_instr_exec_bench
